// file: hdl/shmc_pkg.sv
// constants, register map and types of the slave hardware mode block
//=============================================================
`default_nettype none
package shmc_pkg;
    //=============================================================
    // clock and times
    localparam longint CLK_HZ        = 20_000_000;
    localparam longint NS_PER_S      = 1_000_000_000;
    localparam longint GAP_MICRO_NS  = 1_000;
    localparam longint GAP_MILLI_NS  = 1_000_000;
    localparam longint TICK_SHORT_NS = 1_000_000;
    localparam longint TICK_LONG_NS  = 10_000_000;
    // least times round up
    localparam int unsigned GAP_MICRO_CYC =
        int'((GAP_MICRO_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int unsigned GAP_MILLI_CYC_DEF =
        int'((GAP_MILLI_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S);
    localparam int unsigned TICK_SHORT_CYC_DEF = int'(TICK_SHORT_NS * CLK_HZ / NS_PER_S);
    localparam int unsigned TICK_LONG_CYC_DEF  = int'(TICK_LONG_NS * CLK_HZ / NS_PER_S);
    localparam int CNT_W = 18;

    //=============================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_TICKS  = 8'h0C;

    // status and mask bit positions
    localparam int STAT_W      = 3;
    localparam int STAT_TICK   = 0;
    localparam int STAT_ACCEPT = 1;
    localparam int STAT_REJECT = 2;

    // control fields, bit 8 downward
    typedef struct packed {
        logic freeze_supported;
        logic sync_supported;
        logic host_byte_order_select;
        logic failsafe_accept;
        logic tick_period_select;
        logic irq_gap_select;
        logic slave_protocol_enable;
        logic early_ready;
        logic irq_polarity_high;
    } shmc_ctrl_t;
    localparam int CTRL_W = 9;
    localparam logic [8:0] CTRL_RST = 9'h000;
    localparam logic [2:0] MASK_RST = 3'h0;

    // interrupt pin sequencer, gray coded except the gap to idle step, which flips both bits
    typedef enum logic [1:0] {
        IRQ_IDLE = 2'b00,
        IRQ_ACT  = 2'b01,
        IRQ_GAP  = 2'b11
    } shmc_irq_st_t;
endpackage
`default_nettype wire

// file: hdl/shmc_top.sv
// slave hardware mode settings, user tick timer and interrupt pin
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module shmc_top #(
    parameter int unsigned GAP_MILLI_CYC  = shmc_pkg::GAP_MILLI_CYC_DEF,
    parameter int unsigned TICK_SHORT_CYC = shmc_pkg::TICK_SHORT_CYC_DEF,
    parameter int unsigned TICK_LONG_CYC  = shmc_pkg::TICK_LONG_CYC_DEF
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic [31:0] hrdata,
    input  wire logic        rx_valid,
    input  wire logic        rx_has_output,
    output var  logic        rx_accept,
    output var  logic        rx_reject,
    output var  logic        slave_access_points,
    output var  logic        irq_pin
);
    import shmc_pkg::*;

    //=============================================================
    // bus slave
    shmc_ctrl_t         ctrl_r;
    logic [STAT_W-1:0]  status_r, mask_r;
    logic [15:0]        tick_count_r;
    logic               dph_r, wr_r;
    logic [7:0]         addr_r;
    logic [31:0]        rd_mux;
    logic [15:0]        ticks_host;

    wire addr_ok  = hsel & htrans[1] & hready;
    wire wr_fire  = dph_r & wr_r & hreadyout;
    wire wr_ctrl  = wr_fire & (addr_r == ADDR_CTRL);
    wire wr_stat  = wr_fire & (addr_r == ADDR_STATUS);
    wire wr_mask  = wr_fire & (addr_r == ADDR_MASK);

    // little style keeps the low byte first, big style swaps the bytes
    assign ticks_host = ctrl_r.host_byte_order_select ? tick_count_r
                      : {tick_count_r[7:0], tick_count_r[15:8]};

    always_comb begin
        unique case (haddr[7:0])
            ADDR_CTRL:   rd_mux = {23'h00_0000, ctrl_r};
            ADDR_STATUS: rd_mux = {29'h0000_0000, status_r};
            ADDR_MASK:   rd_mux = {29'h0000_0000, mask_r};
            ADDR_TICKS:  rd_mux = {16'h0000, ticks_host};
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait state unless early ready is set
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dph_r     <= 1'b0;
            wr_r      <= 1'b0;
            addr_r    <= 8'h00;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
        end else if (addr_ok) begin
            dph_r     <= 1'b1;
            wr_r      <= hwrite;
            addr_r    <= haddr[7:0];
            hrdata    <= hwrite ? 32'h0000_0000 : rd_mux;
            hreadyout <= ctrl_r.early_ready;
        end else if (dph_r && !hreadyout) begin
            hreadyout <= 1'b1;
        end else begin
            dph_r     <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) hresp <= 1'b0;
        else hresp <= 1'b0;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RST;
            mask_r <= MASK_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= hwdata[CTRL_W-1:0];
            if (wr_mask) mask_r <= hwdata[STAT_W-1:0];
        end
    end

    //=============================================================
    // user tick timer, free running on the core clock
    logic [CNT_W-1:0] tick_cnt_r;
    logic             tick_sel_used_r;
    wire              tick_hit = (tick_cnt_r == '0);
    wire [CNT_W-1:0]  tick_load = ctrl_r.tick_period_select
                      ? CNT_W'(TICK_LONG_CYC - 1) : CNT_W'(TICK_SHORT_CYC - 1);

    // a new period setting takes effect at the next reload
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r      <= CNT_W'(TICK_SHORT_CYC - 1);
            tick_sel_used_r <= 1'b0;
            tick_count_r    <= 16'h0000;
        end else if (tick_hit) begin
            tick_cnt_r      <= tick_load;
            tick_sel_used_r <= ctrl_r.tick_period_select;
            tick_count_r    <= tick_count_r + 16'h0001;
        end else begin
            tick_cnt_r      <= tick_cnt_r - CNT_W'(1);
        end
    end

    //=============================================================
    // telegram acceptance
    wire tg_ok   = rx_valid & ctrl_r.slave_protocol_enable
                 & (rx_has_output | ctrl_r.failsafe_accept);
    wire tg_bad  = rx_valid & ~tg_ok;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_accept           <= 1'b0;
            rx_reject           <= 1'b0;
            slave_access_points <= 1'b0;
        end else begin
            rx_accept           <= tg_ok;
            rx_reject           <= tg_bad;
            slave_access_points <= ctrl_r.slave_protocol_enable;
        end
    end

    //=============================================================
    // sticky status, write one to clear; a set in the same cycle wins
    wire [STAT_W-1:0] stat_set = {tg_bad, tg_ok, tick_hit};
    wire [STAT_W-1:0] stat_clr = wr_stat ? hwdata[STAT_W-1:0] : '0;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) status_r <= '0;
        else status_r <= (status_r & ~stat_clr) | stat_set;
    end

    //=============================================================
    // interrupt pin with enforced inactive gap
    shmc_irq_st_t     irq_st_r, irq_st_nxt;
    logic [CNT_W-1:0] gap_cnt_r, gap_cnt_nxt;
    wire pend = |(status_r & mask_r);
    wire [CNT_W-1:0] gap_load = ctrl_r.irq_gap_select
                     ? CNT_W'(GAP_MILLI_CYC - 1) : CNT_W'(GAP_MICRO_CYC - 1);

    always_comb begin
        irq_st_nxt  = irq_st_r;
        gap_cnt_nxt = gap_cnt_r;
        unique case (irq_st_r)
            IRQ_IDLE: if (pend) irq_st_nxt = IRQ_ACT;
            IRQ_ACT: if (!pend) begin
                irq_st_nxt  = IRQ_GAP;
                gap_cnt_nxt = gap_load;
            end
            IRQ_GAP: if (gap_cnt_r == '0) begin
                irq_st_nxt = pend ? IRQ_ACT : IRQ_IDLE;
            end else begin
                gap_cnt_nxt = gap_cnt_r - CNT_W'(1);
            end
            default: irq_st_nxt = IRQ_IDLE;
        endcase
    end

    // pin resets to the low-active idle level, the reset polarity
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_st_r  <= IRQ_IDLE;
            gap_cnt_r <= '0;
            irq_pin   <= 1'b1;
        end else begin
            irq_st_r  <= irq_st_nxt;
            gap_cnt_r <= gap_cnt_nxt;
            irq_pin   <= (irq_st_nxt == IRQ_ACT) ~^ ctrl_r.irq_polarity_high;
        end
    end

    //=============================================================
    // checks
    logic [CNT_W-1:0] gap_len_r, tick_since_r;
    logic             gap_used_r;
    wire [15:0]       ticks_swapped = {tick_count_r[7:0], tick_count_r[15:8]};
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_len_r    <= '0;
            gap_used_r   <= 1'b0;
            tick_since_r <= '0;
        end else begin
            gap_len_r    <= (irq_st_r == IRQ_GAP) ? gap_len_r + CNT_W'(1) : '0;
            if (irq_st_r == IRQ_ACT) gap_used_r <= ctrl_r.irq_gap_select;
            tick_since_r <= tick_hit ? '0 : tick_since_r + CNT_W'(1);
        end
    end

    chk_pin_polarity: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $stable(ctrl_r.irq_polarity_high) |->
        ((irq_st_r == IRQ_ACT) == (irq_pin == ctrl_r.irq_polarity_high)))
        else $error("interrupt pin level does not match polarity");
    chk_ready_early: assert property (@(posedge ref_clk) disable iff (sys_rst)
        addr_ok && ctrl_r.early_ready |=> hreadyout)
        else $error("early ready did not answer at once");
    chk_ready_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        addr_ok && !ctrl_r.early_ready |=> !hreadyout ##1 hreadyout)
        else $error("normal ready is not one wait state");
    chk_sap_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_ctrl |=> ##1 (slave_access_points == $past(hwdata[2], 2)))
        else $error("access points do not follow protocol enable");
    chk_gap_length: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_st_r == IRQ_GAP && irq_st_nxt != IRQ_GAP |->
        gap_len_r + CNT_W'(1) == (gap_used_r ? CNT_W'(GAP_MILLI_CYC) : CNT_W'(GAP_MICRO_CYC)))
        else $error("interrupt inactive gap has wrong length");
    chk_tick_period: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_hit |-> tick_since_r + CNT_W'(1) ==
        (tick_sel_used_r ? CNT_W'(TICK_LONG_CYC) : CNT_W'(TICK_SHORT_CYC)))
        else $error("tick period wrong");
    chk_tick_gated: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !pend && irq_st_r != IRQ_ACT |=> irq_st_r != IRQ_ACT)
        else $error("interrupt raised without an enabled event");
    chk_tick_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_hit |=> status_r[STAT_TICK])
        else $error("tick did not set its status bit");
    chk_failsafe_tg: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_valid && !rx_has_output && ctrl_r.slave_protocol_enable |=>
        (rx_accept == $past(ctrl_r.failsafe_accept)) && (rx_reject != rx_accept))
        else $error("fail-safe telegram handled wrongly");
    chk_byte_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
        addr_ok && !hwrite && haddr[7:0] == ADDR_TICKS && !ctrl_r.host_byte_order_select
        |=> hrdata[15:0] == $past(ticks_swapped))
        else $error("word read not byte swapped");
    cov_irq_cycle: cover property (@(posedge ref_clk) disable iff (sys_rst)
        irq_st_r == IRQ_ACT ##1 irq_st_r == IRQ_GAP);
    cov_tick_long: cover property (@(posedge ref_clk) disable iff (sys_rst)
        tick_hit && tick_sel_used_r);
    cov_failsafe_ok: cover property (@(posedge ref_clk) disable iff (sys_rst)
        rx_valid && !rx_has_output && tg_ok);
    chk_irq_raise: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_st_r == IRQ_IDLE && pend
        |=> irq_st_r == IRQ_ACT)
        else $error("enabled event did not raise the interrupt");
    chk_irq_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_st_r == IRQ_ACT && pend
        |=> irq_st_r == IRQ_ACT)
        else $error("interrupt dropped while an event pends");
    chk_irq_release: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_st_r == IRQ_ACT && !pend
        |=> irq_st_r == IRQ_GAP)
        else $error("interrupt end did not start the inactive gap");
    chk_gap_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        irq_st_r == IRQ_GAP && gap_cnt_r != '0
        |=> irq_st_r == IRQ_GAP)
        else $error("inactive gap cut short");
    chk_tg_accept: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_valid && ctrl_r.slave_protocol_enable && rx_has_output
        |=> rx_accept && !rx_reject)
        else $error("data telegram not accepted");
    chk_tg_closed: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_valid && !ctrl_r.slave_protocol_enable
        |=> !rx_accept && rx_reject)
        else $error("telegram accepted while protocol disabled");
    chk_tg_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_valid && !rx_has_output && !ctrl_r.failsafe_accept
        |=> !rx_accept && rx_reject)
        else $error("fail-safe telegram accepted without the setting");
    chk_tg_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !rx_valid
        |=> !rx_accept && !rx_reject)
        else $error("telegram answer without a telegram");
    chk_stat_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_stat && hwdata[STAT_TICK] && !tick_hit
        |=> !status_r[STAT_TICK])
        else $error("tick status not cleared by a one");
    chk_stat_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        status_r[STAT_ACCEPT] && !(wr_stat && hwdata[STAT_ACCEPT])
        |=> status_r[STAT_ACCEPT])
        else $error("accept status lost without a clear");
    chk_ctrl_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wr_ctrl
        |=> ctrl_r == $past(hwdata[CTRL_W-1:0]))
        else $error("control write did not land");
    chk_tick_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_hit
        |=> tick_count_r == $past(tick_count_r) + 16'h0001)
        else $error("tick count did not advance");
    chk_tick_reload: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tick_hit
        |=> tick_cnt_r == $past(tick_load))
        else $error("tick timer reloaded with wrong period");
    chk_byte_little: assert property (@(posedge ref_clk) disable iff (sys_rst)
        addr_ok && !hwrite && haddr[7:0] == ADDR_TICKS && ctrl_r.host_byte_order_select
        |=> hrdata[15:0] == $past(tick_count_r))
        else $error("word read not in low byte first order");
    cov_early_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
        addr_ok && !hwrite && ctrl_r.early_ready);
    cov_tg_reject: cover property (@(posedge ref_clk) disable iff (sys_rst)
        rx_reject && $past(ctrl_r.slave_protocol_enable));
endmodule // shmc_top
`default_nettype wire

// file: tb/shmc_host_model.sv
// host side model: single-word ahb-lite master
`timescale 1ns/1ps
`default_nettype none
module shmc_host_model (
    input  wire logic        ref_clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output var  logic        hsel,
    output var  logic [31:0] haddr,
    output var  logic [1:0]  htrans,
    output var  logic        hwrite,
    output var  logic [2:0]  hsize,
    output var  logic [31:0] hwdata,
    output var  logic        done,
    output var  logic [31:0] rdata
);
    int waits;
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
        done   = 1'b0;
        rdata  = 32'h0000_0000;
    end
    //=============================================================
    // one transfer; wait states are counted, never assumed
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        haddr  <= ~haddr;
        hwdata <= d;
        waits = 0;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            waits++;
            @(posedge ref_clk);
        end
        rdata  <= hrdata;
        done   <= ~w;
        // released data lines do not keep the last word
        hwdata <= ~d;
        @(posedge ref_clk);
        done   <= 1'b0;
    endtask
endmodule // shmc_host_model
`default_nettype wire

// file: tb/shmc_tb.sv
// self-checking bench of the slave hardware mode block
`timescale 1ns/1ps
`default_nettype none
module shmc_tb;
    import shmc_pkg::*;
    logic             ref_clk = 1'b0;
    logic             sys_rst = 1'b1;
    logic             rx_valid = 1'b0;
    logic             rx_has_output = 1'b0;
    wire logic        hsel, hwrite, hready, hresp, rx_accept, rx_reject, sap, irq_pin, hdone;
    wire logic [31:0] haddr, hwdata, hrdata, hr;
    wire logic [1:0]  htrans;
    wire logic [2:0]  hsize;
    int               n_errors = 0;
    int               comparisons = 0;
    logic [63:0]      rq[$];
    logic [1:0]       tq[$];
    logic [63:0]      re;
    logic [1:0]       te;
    logic             v1 = 1'b0;
    logic             arm = 1'b0;
    logic             pol = 1'b0;
    int               gap = 0;
    int               gcnt = 0;
    int               k;
    logic [15:0]      lf = 16'h3A15;
    logic [15:0]      t0, t1;
    shmc_ctrl_t       cf;

    always #25 ref_clk = ~ref_clk;

    shmc_top #(.GAP_MILLI_CYC(50), .TICK_SHORT_CYC(40), .TICK_LONG_CYC(100)) DUT (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .rx_valid(rx_valid), .rx_has_output(rx_has_output), .rx_accept(rx_accept),
        .rx_reject(rx_reject), .slave_access_points(sap), .irq_pin(irq_pin));
    shmc_host_model host (
        .ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .done(hdone), .rdata(hr));

    //=============================================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rq.push_back({m, e});
        host.xfer(1'b0, a, 32'h0000_0000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    //=============================================================
    // output watchers: oldest note against each result
    always @(posedge ref_clk) begin
        v1 <= rx_valid;
        if (!sys_rst && (v1 || rx_accept !== 1'b0 || rx_reject !== 1'b0)) begin
            te = tq.size() > 0 ? tq.pop_front() : 2'h0;
            chk({30'h0, rx_accept, rx_reject}, {30'h0, te}, "telegram");
        end
        if (hdone === 1'b1) begin
            re = rq.pop_front();
            chk(hr & re[63:32], re[31:0], "read data");
            chk({31'h0, hresp}, 32'h0000_0000, "okay response");
        end
        // idle run before each activation; starts high so arming never trips it
        if (!arm)
            gcnt <= 1000;
        else if (irq_pin === pol) begin
            if (gcnt != 0)
                chk({31'h0, gcnt >= gap}, 32'h0000_0001, "inactive gap");
            gcnt <= 0;
        end else
            gcnt <= gcnt + 1;
    end

    initial begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        give_verdict();
    end

    //=============================================================
    // main sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        chk(32'(host.waits), 32'h0000_0001, "one wait state");
        chk({31'h0, irq_pin}, 32'h0000_0001, "idle pin");
        wr(ADDR_CTRL, 32'h0000_0182);
        rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0182);
        chk(32'(host.waits), 32'h0000_0000, "early ready");
        rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        repeat (50) @(posedge ref_clk);
        rd(ADDR_STATUS, 32'hFFFF_FFFF, 32'h0000_0001);
        chk({31'h0, irq_pin}, 32'h0000_0001, "masked tick");
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            cf = '0;
            cf.early_ready = 1'b1;
            cf.slave_protocol_enable = c[0];
            cf.failsafe_accept = c[1];
            wr(ADDR_CTRL, {23'h0, cf});
            repeat (2) @(negedge ref_clk);
            chk({31'h0, sap}, {31'h0, c[0]}, "access points");
            // back-to-back telegrams
            for (int i = 0; i < 8; i++) begin
                @(posedge ref_clk);
                lf = lfsr(lf);
                rx_valid <= 1'b1;
                rx_has_output <= lf[0];
                tq.push_back({c[0] & (lf[0] | c[1]), !(c[0] & (lf[0] | c[1]))});
            end
            @(posedge ref_clk);
            rx_valid <= 1'b0;
            rx_has_output <= ~rx_has_output;
            repeat (3) @(posedge ref_clk);
        end
        $display("test telegrams done");
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_MASK, 32'h0000_0000);
            wr(ADDR_STATUS, 32'h0000_0007);
            cf = '0;
            cf.early_ready = 1'b1;
            cf.irq_polarity_high = c[0];
            cf.irq_gap_select = c[1];
            wr(ADDR_CTRL, {23'h0, cf});
            pol <= c[0];
            gap <= c[1] ? 50 : GAP_MICRO_CYC;
            repeat (60) @(negedge ref_clk);
            chk({31'h0, irq_pin}, {31'h0, ~pol}, "masked pin idle");
            arm <= 1'b1;
            wr(ADDR_MASK, 32'h0000_0001);
            repeat (3) begin
                // wait up to 200 cycles for the next tick to drive the pin active
                @(negedge ref_clk);
                k = 0;
                while (irq_pin !== pol && k < 200) begin
                    k++;
                    @(negedge ref_clk);
                end
                chk({31'h0, irq_pin}, {31'h0, pol}, "pin active");
                wr(ADDR_STATUS, 32'h0000_0001);
            end
            arm <= 1'b0;
        end
        $display("test interrupt done");
        for (int s = 0; s < 2; s++) begin
            cf = '0;
            cf.early_ready = 1'b1;
            cf.tick_period_select = s[0];
            cf.host_byte_order_select = ~s[0];
            wr(ADDR_CTRL, {23'h0, cf});
            repeat (200) @(posedge ref_clk);
            rd(ADDR_TICKS, 32'hFFFF_0000, 32'h0000_0000);
            t0 = s ? {hr[7:0], hr[15:8]} : hr[15:0];
            repeat (4000) @(posedge ref_clk);
            rd(ADDR_TICKS, 32'hFFFF_0000, 32'h0000_0000);
            t1 = (s ? {hr[7:0], hr[15:8]} : hr[15:0]) - t0;
            k = s ? 40 : 100;
            chk({31'h0, t1 >= k - 1 && t1 <= k + 1}, 32'h0000_0001, "ticks");
        end
        $display("test tick timer done");
        give_verdict();
    end
endmodule // shmc_tb
`default_nettype wire
